/* File: logic/dseh_defines.svh */
/*
 * Offsets, field positions, reset values and timing figures of the
 * satellite exception handler.
 * Assumes inclusion by bare name from the logic folder.
 */
`ifndef DSEH_DEFINES_SVH
`define DSEH_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DSEH_ADDR_W        4
`define DSEH_ADDR_CTRL     4'h0
`define DSEH_ADDR_STATUS   4'h4
`define DSEH_ADDR_IRQ_STAT 4'h8
`define DSEH_ADDR_IRQ_MASK 4'hC

// ----------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------
`define DSEH_CTRL_PERIODIC 0
`define DSEH_CTRL_SELFTEST 1
`define DSEH_CTRL_SWITCH   2
`define DSEH_ST_PENDING    0
`define DSEH_ST_BUSUV      1
`define DSEH_ST_HELD       2
`define DSEH_ST_CAPFAIL    3
`define DSEH_ST_SWITCH     4
`define DSEH_ST_SELFTEST   5
`define DSEH_IRQ_W         4
`define DSEH_IRQ_BUSUV     0
`define DSEH_IRQ_REGUV     1
`define DSEH_IRQ_CAPFAIL   2
`define DSEH_IRQ_WRBLOCK   3

// ----------------------------------------------------------------------
// Pin inputs
// ----------------------------------------------------------------------
`define DSEH_NUM_PINS      6
`define DSEH_PIN_BUSUV     0
`define DSEH_PIN_VREGUV    1
`define DSEH_PIN_VREGAUV   2
`define DSEH_PIN_CAP_LO    3
`define DSEH_PIN_CAP_HI    5

// ----------------------------------------------------------------------
// Codes and timing
// ----------------------------------------------------------------------
`define DSEH_CODE_NORMAL   4'h0
`define DSEH_CODE_PENDING  4'h8
`define DSEH_CLK_PERIOD_NS 25
`define DSEH_SWITCH_OFF_NS 1000
`define DSEH_SWITCH_OFF_CYC (`DSEH_SWITCH_OFF_NS / `DSEH_CLK_PERIOD_NS)
`define DSEH_RETRY_US      1000
`define DSEH_RESET_PULSE   16

`endif

/* File: logic/dseh_pkg.sv */
/*
 * Types shared by the satellite exception handler.
 * Assumes the command decoder presents one decoded command per cycle.
 */
package dseh_pkg;

	// ------------------------------------------------------------------
	// Decoded bus command
	// ------------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic read;
		logic write;
		logic background;
	} dseh_cmd_t;

	// ------------------------------------------------------------------
	// Exception state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		DSEH_RUN,
		DSEH_HOLD_UV,
		DSEH_CAP_PULSE,
		DSEH_CAP_WAIT
	} dseh_state_t;

endpackage : dseh_pkg

/* File: logic/dseh_exception.sv */
/*
 * Exception handler and background command filter of a bus satellite.
 * Assumes a decoded command input on clk and analog monitor pins that
 * arrive asynchronously.
 */
// Contract
// - With periodic mode on, a background register read is accepted and executed.
// - A background register write is never executed; in periodic mode it sets the write-block interrupt flag.
// - After reset, pending flag set and status code 1000 until self-test.
// - Bus input undervoltage sets a flag, decoding continues, response current off.
// - Regulator undervoltage holds the device in reset while it persists.
// - While held in reset no bus command gets any response.
// - Any reset-class exception switches the daisy-chain switch off in time.
// - Capacitor failure resets the device once every retry period until gone.
// - Self-test activation with periodic mode off clears the pending flag and enables the stimulus.
`timescale 1ns/1ps
`include "dseh_defines.svh"

module dseh_exception #(
	parameter int RETRY_PERIOD_US = `DSEH_RETRY_US
) (
	// Clock, reset and enable
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      ce,
	// Register port
	input  wire logic [`DSEH_ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [31:0]               reg_rdata,
	// Analog monitor pins
	input  wire logic [`DSEH_NUM_PINS-1:0] monitor_pins,
	// Decoded bus command
	input  wire dseh_pkg::dseh_cmd_t       cmd,
	// Command results
	output logic                           read_exec,
	output logic                           write_exec,
	output logic                           resp_current_en,
	output logic [3:0]                     status_code,
	// Device control
	output logic                           core_reset_hold,
	output logic                           daisy_chain_switch,
	output logic                           selftest_enable,
	output logic                           irq
);
	import dseh_pkg::*;

	localparam int RETRY_CYCLES =
		(RETRY_PERIOD_US * 1000) / `DSEH_CLK_PERIOD_NS;
	localparam int CNT_W = $clog2(RETRY_CYCLES + 1);

	// ------------------------------------------------------------------
	// Pin synchronisers, a change counts when stages two and three agree
	// ------------------------------------------------------------------
	logic [`DSEH_NUM_PINS-1:0] sync1;
	logic [`DSEH_NUM_PINS-1:0] sync2;
	logic [`DSEH_NUM_PINS-1:0] sync3;
	logic [`DSEH_NUM_PINS-1:0] pin_lvl;

	genvar gi;
	generate
		for (gi = 0; gi < `DSEH_NUM_PINS; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					sync1[gi]   <= 1'b0;
					sync2[gi]   <= 1'b0;
					sync3[gi]   <= 1'b0;
					pin_lvl[gi] <= 1'b0;
				end else if (ce) begin
					sync1[gi] <= monitor_pins[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi]) begin
						pin_lvl[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	logic bus_uv;
	logic reg_uv;
	logic cap_fail;
	assign bus_uv   = pin_lvl[`DSEH_PIN_BUSUV];
	assign reg_uv   = pin_lvl[`DSEH_PIN_VREGUV] | pin_lvl[`DSEH_PIN_VREGAUV];
	assign cap_fail = |pin_lvl[`DSEH_PIN_CAP_HI:`DSEH_PIN_CAP_LO];

	// ------------------------------------------------------------------
	// Exception state machine
	// ------------------------------------------------------------------
	dseh_state_t      state;
	dseh_state_t      next_state;
	logic [CNT_W-1:0] cnt;
	logic             held;

	always_comb begin
		next_state = state;
		case (state)
			DSEH_RUN: begin
				if (reg_uv) begin
					next_state = DSEH_HOLD_UV;
				end else if (cap_fail) begin
					next_state = DSEH_CAP_PULSE;
				end
			end
			DSEH_HOLD_UV: begin
				if (!reg_uv) begin
					next_state = DSEH_RUN;
				end
			end
			DSEH_CAP_PULSE: begin
				if (reg_uv) begin
					next_state = DSEH_HOLD_UV;
				end else if (cnt == CNT_W'(`DSEH_RESET_PULSE - 1)) begin
					next_state = DSEH_CAP_WAIT;
				end
			end
			DSEH_CAP_WAIT: begin
				if (reg_uv) begin
					next_state = DSEH_HOLD_UV;
				end else if (!cap_fail) begin
					next_state = DSEH_RUN;
				end else if (cnt == CNT_W'(RETRY_CYCLES - 1)) begin
					next_state = DSEH_CAP_PULSE;
				end
			end
			default: next_state = DSEH_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= DSEH_RUN;
			cnt   <= '0;
		end else if (ce) begin
			state <= next_state;
			if (next_state != state) begin
				cnt <= '0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	assign held = (next_state != DSEH_RUN);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			core_reset_hold <= 1'b0;
		end else if (ce) begin
			core_reset_hold <= (next_state == DSEH_HOLD_UV) ||
				(next_state == DSEH_CAP_PULSE);
		end
	end

	// ------------------------------------------------------------------
	// Control register, cleared by every internal reset
	// ------------------------------------------------------------------
	logic periodic_mode_enable;
	logic switch_req;
	logic selftest_pending_flag;
	logic st_write;
	assign st_write = reg_wr && (reg_addr == `DSEH_ADDR_CTRL) &&
		reg_wdata[`DSEH_CTRL_SELFTEST];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			periodic_mode_enable <= 1'b0;
			switch_req           <= 1'b0;
		end else if (ce) begin
			if (held) begin
				periodic_mode_enable <= 1'b0;
				switch_req           <= 1'b0;
			end else if (reg_wr && reg_addr == `DSEH_ADDR_CTRL) begin
				periodic_mode_enable <= reg_wdata[`DSEH_CTRL_PERIODIC];
				switch_req           <= reg_wdata[`DSEH_CTRL_SWITCH];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			selftest_pending_flag <= 1'b1;
			selftest_enable       <= 1'b0;
		end else if (ce) begin
			if (held) begin
				selftest_pending_flag <= 1'b1;
				selftest_enable       <= 1'b0;
			end else if (st_write && !periodic_mode_enable) begin
				selftest_pending_flag <= 1'b0;
				selftest_enable       <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			daisy_chain_switch <= 1'b0;
			status_code        <= `DSEH_CODE_PENDING;
		end else if (ce) begin
			daisy_chain_switch <= switch_req && !held;
			status_code <= selftest_pending_flag ?
				`DSEH_CODE_PENDING : `DSEH_CODE_NORMAL;
		end
	end

	// ------------------------------------------------------------------
	// Command filter
	// ------------------------------------------------------------------
	logic cmd_ok;
	logic wr_blocked;
	assign cmd_ok     = cmd.valid && !held &&
		(!cmd.background || periodic_mode_enable);
	assign wr_blocked = cmd_ok && cmd.write && cmd.background;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			read_exec       <= 1'b0;
			write_exec      <= 1'b0;
			resp_current_en <= 1'b0;
		end else if (ce) begin
			read_exec       <= cmd_ok && cmd.read;
			write_exec      <= cmd_ok && cmd.write && !cmd.background;
			resp_current_en <= !held && !bus_uv;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts, write one to clear, a new event wins over the clear
	// ------------------------------------------------------------------
	logic [`DSEH_IRQ_W-1:0] irq_stat;
	logic [`DSEH_IRQ_W-1:0] irq_mask;
	logic [`DSEH_IRQ_W-1:0] events;
	logic [`DSEH_IRQ_W-1:0] clr;
	logic                   bus_uv_d;
	logic                   reg_uv_d;
	logic                   cap_d;

	assign events = {wr_blocked, cap_fail & ~cap_d,
		reg_uv & ~reg_uv_d, bus_uv & ~bus_uv_d};
	assign clr = (reg_wr && reg_addr == `DSEH_ADDR_IRQ_STAT) ?
		reg_wdata[`DSEH_IRQ_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus_uv_d <= 1'b0;
			reg_uv_d <= 1'b0;
			cap_d    <= 1'b0;
			irq_stat <= '0;
			irq_mask <= '0;
			irq      <= 1'b0;
		end else if (ce) begin
			bus_uv_d <= bus_uv;
			reg_uv_d <= reg_uv;
			cap_d    <= cap_fail;
			irq_stat <= (irq_stat & ~clr) | events;
			if (reg_wr && reg_addr == `DSEH_ADDR_IRQ_MASK) begin
				irq_mask <= reg_wdata[`DSEH_IRQ_W-1:0];
			end
			irq <= |(((irq_stat & ~clr) | events) & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (ce) begin
			reg_rdata <= '0;
			if (reg_rd) begin
				if (reg_addr == `DSEH_ADDR_CTRL) begin
					reg_rdata[`DSEH_CTRL_PERIODIC] <= periodic_mode_enable;
					reg_rdata[`DSEH_CTRL_SWITCH]   <= switch_req;
				end else if (reg_addr == `DSEH_ADDR_STATUS) begin
					reg_rdata[`DSEH_ST_PENDING]  <= selftest_pending_flag;
					reg_rdata[`DSEH_ST_BUSUV]    <= bus_uv;
					reg_rdata[`DSEH_ST_HELD]     <= held;
					reg_rdata[`DSEH_ST_CAPFAIL]  <= cap_fail;
					reg_rdata[`DSEH_ST_SWITCH]   <= daisy_chain_switch;
					reg_rdata[`DSEH_ST_SELFTEST] <= selftest_enable;
				end else if (reg_addr == `DSEH_ADDR_IRQ_STAT) begin
					reg_rdata[`DSEH_IRQ_W-1:0] <= irq_stat;
				end else if (reg_addr == `DSEH_ADDR_IRQ_MASK) begin
					reg_rdata[`DSEH_IRQ_W-1:0] <= irq_mask;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_bdm_read_exec: assert property (ce && cmd.valid && cmd.read &&
		cmd.background && periodic_mode_enable && !held |=> read_exec)
		else $error("Background read was not executed.");
	a_bdm_write_block: assert property (ce && cmd.background |=>
		!write_exec)
		else $error("Background write was executed.");
	a_pending_code: assert property (selftest_pending_flag && ce |=>
		status_code == `DSEH_CODE_PENDING)
		else $error("Pending status code missing.");
	a_busuv_no_current: assert property (ce && bus_uv |=>
		!resp_current_en)
		else $error("Response current during bus undervoltage.");
	a_uv_hold: assert property (ce && reg_uv |=>
		core_reset_hold)
		else $error("Regulator undervoltage did not hold reset.");
	a_held_silent: assert property (ce && held |=>
		!read_exec && !write_exec && !resp_current_en)
		else $error("Response given while held.");
	a_switch_off: assert property (ce && held |=>
		!daisy_chain_switch)
		else $error("Switch not off after exception.");
	a_cap_retry: assert property (ce && state == DSEH_CAP_WAIT &&
		cap_fail && !reg_uv && cnt == CNT_W'(RETRY_CYCLES - 1) |=>
		state == DSEH_CAP_PULSE ##1 core_reset_hold)
		else $error("Capacitor retry reset missing.");
	a_selftest_on: assert property (ce && st_write && !held &&
		!periodic_mode_enable |=> selftest_enable &&
		!selftest_pending_flag)
		else $error("Self-test activation not taken.");
	a_switch_setup: assert property ($rose(daisy_chain_switch) |->
		$past(switch_req))
		else $error("Switch enabled without setup.");

	c_bdm_read: cover property (ce && read_exec && periodic_mode_enable);
	c_cap_retry: cover property (state == DSEH_CAP_WAIT ##1
		state == DSEH_CAP_PULSE);
	c_uv_recover: cover property (state == DSEH_HOLD_UV ##1
		state == DSEH_RUN);

endmodule : dseh_exception

/* File: testbench/dseh_master_model.sv */
/*
 * Behavioural bus master that hands decoded commands to the handler.
 * Assumes the bench asks for one command at a time on go.
 */
`timescale 1ns/1ps

module dseh_master_model #(
	parameter int MAX_SLAVES = 15
) (
	// Clock
	input  wire logic          clk,
	// Request from the bench
	input  wire logic          go,
	input  wire logic          rd,
	input  wire logic          wr,
	input  wire logic          bg,
	input  wire logic [3:0]    node,
	// Command to the slave
	output dseh_pkg::dseh_cmd_t cmd
);
	import dseh_pkg::*;

	// ------------------------------------------------------------------
	// Command issue
	// ------------------------------------------------------------------
	// Only nodes 1 to MAX_SLAVES are addressed; idle fields toggle.
	initial cmd = 4'h0;
	always @(posedge clk) begin
		if (go && node != 4'h0 && node <= MAX_SLAVES) begin
			cmd <= {1'b1, rd, wr, bg};
		end else begin
			cmd <= {1'b0, ~cmd.read, ~cmd.write, ~cmd.background};
		end
	end

endmodule : dseh_master_model

/* File: testbench/dseh_exception_tb.sv */
/*
 * Self-checking bench of the satellite exception handler.
 * Assumes the handler and the master model are compiled before it.
 */
`timescale 1ns/1ps
`include "dseh_defines.svh"

module dseh_exception_tb;
	import dseh_pkg::*;
	localparam int RETRY = 40;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [5:0]  monitor_pins = 6'h00;
	dseh_cmd_t   cmd;
	logic        read_exec;
	logic        write_exec;
	logic        resp_current_en;
	logic [3:0]  status_code;
	logic        core_reset_hold;
	logic        daisy_chain_switch;
	logic        selftest_enable;
	logic        irq;
	logic        go = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        bg = 1'b0;
	logic [3:0]  node = 4'h1;
	logic [31:0] rnd = 32'h7DFC;
	logic [31:0] rv;
	int          err_total = 0;
	int          cmp_count = 0;
	int          m_periodic = 0;
	int          m_held = 0;
	int          n;

	always #12.5 clk = ~clk;

	dseh_exception #(.RETRY_PERIOD_US(1)) dseh_exception_i (.clk(clk),
		.rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.monitor_pins(monitor_pins), .cmd(cmd), .read_exec(read_exec),
		.write_exec(write_exec), .resp_current_en(resp_current_en),
		.status_code(status_code), .core_reset_hold(core_reset_hold),
		.daisy_chain_switch(daisy_chain_switch),
		.selftest_enable(selftest_enable), .irq(irq));
	dseh_master_model dseh_master_model_i (.clk(clk), .go(go), .rd(rd),
		.wr(wr), .bg(bg), .node(node), .cmd(cmd));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task stop_test;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test

	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t level %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task reg_check(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk_reg(reg_rdata, exp);
	endtask : reg_check

	task cmd_chk(input logic r, input logic w, input logic b);
		logic acc;
		acc = (m_held == 0) && (!b || m_periodic != 0);
		@(posedge clk);
		go <= 1'b1;
		rd <= r;
		wr <= w;
		bg <= b;
		node <= 4'(rnd % 15) + 4'h1;
		rnd = lfsr(rnd);
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
		chk_bit(read_exec, acc & r);
		chk_bit(write_exec, acc & w & !b);
	endtask : cmd_chk

	task wait_hold(input logic lvl);
		n = 0;
		while (core_reset_hold !== lvl && n < 12) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_bit(core_reset_hold, lvl);
		if (core_reset_hold !== lvl) stop_test();
	endtask : wait_hold

	task count_hold(input logic lvl);
		n = 0;
		while (core_reset_hold === lvl && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (core_reset_hold === lvl) begin
			chk_bit(core_reset_hold, !lvl);
			stop_test();
		end
	endtask : count_hold

	task reinit;
		reg_write(`DSEH_ADDR_CTRL, 32'h2);
		reg_write(`DSEH_ADDR_CTRL, 32'h5);
		m_periodic = 1;
		m_held = 0;
		@(posedge clk);
		#1;
		chk_bit(daisy_chain_switch, 1'b1);
	endtask : reinit

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk_reg(32'(status_code), 32'(`DSEH_CODE_PENDING));
		reg_check(`DSEH_ADDR_STATUS, 32'h1);
		cmd_chk(1'b1, 1'b0, 1'b1);
		cmd_chk(1'b1, 1'b0, 1'b0);
		reg_write(`DSEH_ADDR_CTRL, 32'h2);
		@(posedge clk);
		#1;
		chk_bit(selftest_enable, 1'b1);
		chk_reg(32'(status_code), 32'(`DSEH_CODE_NORMAL));
		reg_write(`DSEH_ADDR_CTRL, 32'h5);
		m_periodic = 1;
		reg_check(`DSEH_ADDR_CTRL, 32'h5);
		cmd_chk(1'b1, 1'b0, 1'b1);
		cmd_chk(1'b0, 1'b1, 1'b0);
		cmd_chk(1'b0, 1'b1, 1'b1);
		reg_check(`DSEH_ADDR_IRQ_STAT, 32'h8);
		rv = rnd;
		rnd = lfsr(rnd);
		reg_write(`DSEH_ADDR_IRQ_MASK, rv);
		reg_check(`DSEH_ADDR_IRQ_MASK, rv & 32'hF);
		reg_write(`DSEH_ADDR_IRQ_MASK, 32'h8);
		reg_check(4'h2, 32'h0);
		chk_bit(irq, 1'b1);
		reg_write(`DSEH_ADDR_IRQ_STAT, 32'h8);
		reg_check(`DSEH_ADDR_IRQ_STAT, 32'h0);
		chk_bit(irq, 1'b0);
		@(posedge clk);
		ce <= 1'b0;
		reg_write(`DSEH_ADDR_IRQ_MASK, 32'h0);
		ce <= 1'b1;
		reg_check(`DSEH_ADDR_IRQ_MASK, 32'h8);
		@(posedge clk);
		monitor_pins <= 6'h01;
		repeat (8) @(posedge clk);
		#1;
		chk_bit(resp_current_en, 1'b0);
		cmd_chk(1'b1, 1'b0, 1'b0);
		reg_check(`DSEH_ADDR_STATUS, 32'h32);
		@(posedge clk);
		monitor_pins <= 6'h00;
		repeat (8) @(posedge clk);
		#1;
		chk_bit(resp_current_en, 1'b1);
		reg_check(`DSEH_ADDR_IRQ_STAT, 32'h1);
		reg_write(`DSEH_ADDR_IRQ_STAT, 32'hF);
		for (int k = 1; k < 3; k++) begin
			@(posedge clk);
			monitor_pins <= 6'(1 << k);
			wait_hold(1'b1);
			chk_bit(daisy_chain_switch, 1'b0);
			m_held = 1;
			cmd_chk(1'b1, 1'b0, 1'b0);
			repeat (20) @(posedge clk);
			#1;
			chk_bit(core_reset_hold, 1'b1);
			reg_check(`DSEH_ADDR_STATUS, 32'h5);
			reg_check(`DSEH_ADDR_IRQ_STAT, 32'h2);
			reg_write(`DSEH_ADDR_IRQ_STAT, 32'hF);
			@(posedge clk);
			monitor_pins <= 6'h00;
			wait_hold(1'b0);
			chk_reg(32'(status_code), 32'(`DSEH_CODE_PENDING));
			chk_bit(daisy_chain_switch, 1'b0);
			reg_write(`DSEH_ADDR_CTRL, 32'h1);
			reg_write(`DSEH_ADDR_CTRL, 32'h3);
			reg_check(`DSEH_ADDR_STATUS, 32'h1);
			reg_write(`DSEH_ADDR_CTRL, 32'h0);
			reinit();
		end
		for (int j = 3; j < 6; j++) begin
			@(posedge clk);
			monitor_pins <= 6'(1 << j);
			wait_hold(1'b1);
			chk_bit(daisy_chain_switch, 1'b0);
			count_hold(1'b1);
			chk_reg(n, `DSEH_RESET_PULSE);
			count_hold(1'b0);
			chk_reg(n, RETRY);
			m_held = 1;
			cmd_chk(1'b1, 1'b0, 1'b0);
			reg_check(`DSEH_ADDR_IRQ_STAT, 32'h4);
			reg_write(`DSEH_ADDR_IRQ_STAT, 32'hF);
			@(posedge clk);
			monitor_pins <= 6'h00;
			repeat (RETRY + 30) @(posedge clk);
			#1;
			chk_bit(core_reset_hold, 1'b0);
			reinit();
		end
		stop_test();
	end

endmodule : dseh_exception_tb
